// [verilog/acc_defines.vh]
// Register map, field positions and reset values of the converter controller
`ifndef ACC_DEFINES_VH
`define ACC_DEFINES_VH

`define ACC_ADDR_W 17
`define ACC_DATA_W 16
`define ACC_OFS_CONTROL 17'h1ED00
`define ACC_OFS_RESULT 17'h1ED04
`define ACC_OFS_DIVISOR 17'h1ED08
`define ACC_OFS_READY 17'h1ED0C

`define ACC_START_BIT 0
`define ACC_PD_BIT 1
`define ACC_SEL_LSB 2
`define ACC_SEL_MSB 4
`define ACC_SEL_W 3
`define ACC_DIV_LSB 0
`define ACC_DIV_MSB 7
`define ACC_DIV_W 8
`define ACC_RES_W 10
`define ACC_READY_BIT 0

`define ACC_CONTROL_RST 16'h0004
`define ACC_SEL_RST 3'h1
`define ACC_DIVISOR_RST 8'h00
`define ACC_RESULT_RST 10'h000
`define ACC_START_HOLD 2'h2
`define ACC_ZERO16 16'h0000

`endif

// [verilog/acc_prescaler.v]
// Prescaler giving a one-cycle converter clock enable every divisor+1 bus clocks
`timescale 1ns/1ps
module acc_prescaler #(
  parameter DIV_W = 8
) (
  input wire ref_clk, // Bus clock
  input wire rst, // Asynchronous reset, active high
  input wire [DIV_W-1:0] divisor, // Divide by divisor plus one
  output reg tick_reg // One-cycle converter clock enable
);
  reg [DIV_W-1:0] count_reg;
  reg [DIV_W-1:0] count_next;
  wire wrap;

  // Divisor zero wraps every cycle, so the enable stays high
  assign wrap = (count_reg >= divisor);

  always @* begin
    if (wrap) begin
      count_next = {DIV_W{1'b0}};
    end else begin
      count_next = count_reg + {{(DIV_W-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      count_reg <= {DIV_W{1'b0}};
      tick_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      tick_reg <= wrap;
    end
  end
endmodule

// [verilog/acc_controller.v]
// Converter controller: bus registers, prescaler and converter macro control lines
//
// Functional notes
// - Converter clock equals bus clock over divisor+1
// - Division ratios from one up to 256
// - Three-bit channel field drives input multiplexer
// - Power-down bit one holds converter powered down
// - Start bit self-clears two converter clocks later
// - Ten-bit read-only result in low bits
// - Read-only ready flag at bit zero
// - Ready output low from reset and while converting, high after end of conversion
// - Active-low reset returns registers to initial values
// - Active-high reset output to converter macro
// - Clock divisor resets to zero
`timescale 1ns/1ps
`include "acc_defines.vh"
module acc_controller #(
  parameter ADDR_W = `ACC_ADDR_W,
  parameter DATA_W = `ACC_DATA_W
) (
  input wire ref_clk, // Bus clock, 50 MHz
  input wire reset, // Asynchronous system reset, active high
  input wire controller_reset_n, // Controller reset, active low
  input wire psel, // Peripheral select
  input wire penable, // Second cycle of a bus transfer
  input wire pwrite, // Write when high
  input wire [ADDR_W-1:0] paddr, // Byte address
  input wire [DATA_W-1:0] pwdata, // Write data
  output reg [DATA_W-1:0] prdata_reg, // Read data, valid in access phase
  input wire eoc, // End of conversion from macro
  input wire [`ACC_RES_W-1:0] conv_data, // Converted value from macro
  output reg start_line_reg, // Conversion start to macro
  output reg [`ACC_SEL_W-1:0] channel_select_field_reg, // Multiplexer select
  output reg power_down_line_reg, // Power down to macro
  output reg converter_reset_reg, // Macro reset, active high
  output wire converter_clk_en, // One-cycle converter clock enable
  output reg ready_out_reg // High when idle with data available
);
  wire rst;
  wire wr_access;
  wire rd_setup;
  wire tick;
  wire start_write;
  wire start_done;
  reg [`ACC_DIV_W-1:0] clock_divisor_reg;
  reg [`ACC_RES_W-1:0] conversion_result_reg;
  reg ready_flag_reg;
  reg [1:0] hold_reg;
  reg [DATA_W-1:0] rd_next;

  // Either reset source clears the whole controller
  assign rst = reset | ~controller_reset_n;
  assign wr_access = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign start_write = wr_access && (paddr == `ACC_OFS_CONTROL) && pwdata[`ACC_START_BIT];
  assign start_done = start_line_reg && tick && (hold_reg == `ACC_START_HOLD - 2'h1);

  acc_prescaler #(
    .DIV_W(`ACC_DIV_W)
  ) u_prescaler (
    .ref_clk(ref_clk),
    .rst(rst),
    .divisor(clock_divisor_reg),
    .tick_reg(tick)
  );

  assign converter_clk_en = tick;

  // Control register fields and clock divisor
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      // Select field of the control register reset value
      channel_select_field_reg <= `ACC_SEL_RST;
      power_down_line_reg <= 1'b0;
      clock_divisor_reg <= `ACC_DIVISOR_RST;
    end else if (wr_access) begin
      if (paddr == `ACC_OFS_CONTROL) begin
        channel_select_field_reg <= pwdata[`ACC_SEL_MSB:`ACC_SEL_LSB];
        power_down_line_reg <= pwdata[`ACC_PD_BIT];
      end else if (paddr == `ACC_OFS_DIVISOR) begin
        clock_divisor_reg <= pwdata[`ACC_DIV_MSB:`ACC_DIV_LSB];
      end
    end
  end

  // Start bit: a new write of one wins over the self-clear
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      start_line_reg <= 1'b0;
      hold_reg <= 2'h0;
    end else if (start_write) begin
      start_line_reg <= 1'b1;
      hold_reg <= 2'h0;
    end else if (start_done) begin
      start_line_reg <= 1'b0;
      hold_reg <= 2'h0;
    end else if (start_line_reg && tick) begin
      hold_reg <= hold_reg + 2'h1;
    end
  end

  // Result capture and ready flag; end of conversion wins over a start
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      conversion_result_reg <= `ACC_RESULT_RST;
      ready_flag_reg <= 1'b0;
      ready_out_reg <= 1'b0;
    end else if (eoc) begin
      conversion_result_reg <= conv_data;
      ready_flag_reg <= 1'b1;
      ready_out_reg <= 1'b1;
    end else if (start_write) begin
      ready_flag_reg <= 1'b0;
      ready_out_reg <= 1'b0;
    end
  end

  // Macro reset high during controller reset, released one cycle after
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      converter_reset_reg <= 1'b1;
    end else begin
      converter_reset_reg <= 1'b0;
    end
  end

  // Read mux, sampled in the setup phase; unmapped reads return zero
  always @* begin
    rd_next = `ACC_ZERO16;
    if (paddr == `ACC_OFS_CONTROL) begin
      rd_next[`ACC_SEL_MSB:`ACC_SEL_LSB] = channel_select_field_reg;
      rd_next[`ACC_PD_BIT] = power_down_line_reg;
      rd_next[`ACC_START_BIT] = start_line_reg;
    end else if (paddr == `ACC_OFS_RESULT) begin
      rd_next[`ACC_RES_W-1:0] = conversion_result_reg;
    end else if (paddr == `ACC_OFS_DIVISOR) begin
      rd_next[`ACC_DIV_MSB:`ACC_DIV_LSB] = clock_divisor_reg;
    end else if (paddr == `ACC_OFS_READY) begin
      rd_next[`ACC_READY_BIT] = ready_flag_reg;
    end
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prdata_reg <= `ACC_ZERO16;
    end else if (rd_setup) begin
      prdata_reg <= rd_next;
    end
  end
endmodule

// [verification/acc_asserts.sv]
// Port checks for the converter controller
`timescale 1ns/1ps
module acc_asserts (
  input wire ref_clk, reset, controller_reset_n, psel, penable, pwrite, eoc,
  input wire [16:0] paddr,
  input wire [15:0] pwdata, prdata_reg,
  input wire [2:0] channel_select_field_reg,
  input wire start_line_reg, power_down_line_reg, converter_reset_reg, ready_out_reg
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset || !controller_reset_n);
  wire wr = psel && penable && pwrite && paddr == 17'h1ED00;
  wire rd = psel && !penable && !pwrite && paddr == 17'h1ED0C;
  a_sel_write: assert property (wr |=> channel_select_field_reg == $past(pwdata[4:2]))
    else $error("select wrong");
  a_pd_write: assert property (wr |=> power_down_line_reg == $past(pwdata[1]))
    else $error("power down wrong");
  a_start_set: assert property (wr && pwdata[0] |=> start_line_reg)
    else $error("start not set");
  a_start_span: assert property ($rose(start_line_reg) |->
    start_line_reg[*2] ##[1:600] !start_line_reg) else $error("start span wrong");
  a_ready_low: assert property (wr && pwdata[0] && !eoc |=> !ready_out_reg)
    else $error("ready not low");
  a_ready_eoc: assert property (eoc |=> ready_out_reg)
    else $error("ready not set");
  a_ready_read: assert property (rd |=> prdata_reg == {15'h0000, $past(ready_out_reg)})
    else $error("ready flag read wrong");
  a_macro_rst: assert property (disable iff (1'b0) !controller_reset_n |-> converter_reset_reg)
    else $error("macro reset low");
endmodule

// [verification/acc_conv_model.sv]
// Converter macro model answering a start with a later end of conversion
`timescale 1ns/1ps
module acc_conv_model #(
  parameter TICKS = 4
) (
  input wire ref_clk, // Bus clock
  input wire start_line_reg, // Start
  input wire power_down_line_reg, // Power down
  input wire converter_reset_reg, // Macro reset
  input wire converter_clk_en, // Converter clock enable
  input wire [9:0] sample, // Value to convert
  output reg eoc = 1'b0, // End of conversion
  output reg [9:0] conv_data = 10'h155 // Result, toggles while invalid
);
  reg busy_reg = 1'b0;
  reg [7:0] cnt_reg = 8'h00;
  always @(posedge ref_clk) begin
    eoc <= 1'b0;
    conv_data <= ~conv_data;
    if (converter_reset_reg || power_down_line_reg) begin
      busy_reg <= 1'b0;
    end else if (start_line_reg && !busy_reg) begin
      busy_reg <= 1'b1;
      cnt_reg <= 8'h00;
    end else if (busy_reg && converter_clk_en) begin
      cnt_reg <= cnt_reg + 8'h01;
      if (cnt_reg == TICKS) begin
        busy_reg <= 1'b0;
        eoc <= 1'b1;
        conv_data <= sample;
      end
    end
  end
endmodule

// [verification/tb.sv]
// Self-checking bench for the converter controller
`timescale 1ns/1ps
module tb;
  reg ref_clk = 1'b0, reset = 1'b1, controller_reset_n = 1'b1, psel = 1'b0;
  reg penable = 1'b0, pwrite = 1'b0;
  reg [16:0] paddr = 17'h00000;
  reg [15:0] pwdata = 16'h0000, q;
  reg [9:0] sample = 10'h000;
  wire [15:0] prdata_reg;
  wire [9:0] conv_data;
  wire [2:0] channel_select_field_reg;
  wire eoc, start_line_reg, power_down_line_reg, converter_reset_reg, converter_clk_en;
  wire ready_out_reg;
  integer fails = 0, tests_run = 0, n, c;
  always #10 ref_clk = ~ref_clk;
  acc_controller acc_controller_inst (.*);
  acc_conv_model acc_conv_model_inst (.*);
  task chk(input string nm, input [15:0] e, input [15:0] g);
    tests_run = tests_run + 1;
    if (g !== e) begin
      fails = fails + 1;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task bus(input w, input [16:0] a, input [15:0] d);
    @(posedge ref_clk) #1 {psel, pwrite, paddr, pwdata} = {1'b1, w, a, d};
    @(posedge ref_clk) #1 penable = 1'b1;
    @(posedge ref_clk) q = prdata_reg;
    #1 {psel, penable} = 2'b00;
  endtask
  task rd(input [16:0] a, input [15:0] e, input string nm);
    bus(1'b0, a, 16'h0000);
    chk(nm, e, q);
  endtask
  task t_conv(input [7:0] d, input [9:0] v);
    sample = v;
    bus(1'b1, 17'h1ED08, {8'h00, d});
    bus(1'b1, 17'h1ED00, 16'h0005);
    chk("ready low", 16'h0000, ready_out_reg);
    n = 0;
    while (start_line_reg && n < 600) @(posedge ref_clk) #1 n = n + 1;
    chk("start span", 16'h0001, n >= d + 2 && n <= 2 * d + 2);
    n = 0;
    while (!ready_out_reg && n < 2000) @(posedge ref_clk) #1 n = n + 1;
    chk("ready out", 16'h0001, ready_out_reg);
    rd(17'h1ED0C, 16'h0001, "ready flag");
    rd(17'h1ED04, {6'h00, v}, "result");
    bus(1'b1, 17'h1ED04, 16'hFFFF);
    rd(17'h1ED04, {6'h00, v}, "result kept");
    rd(17'h1ED08, {8'h00, d}, "divisor");
    $display("conversion test end");
  endtask
  task end_of_test;
    $display("fails %0d tests_run %0d", fails, tests_run);
    if (fails == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    #200000 fails = fails + 1;
    end_of_test;
  end
  initial begin
    repeat (8) @(posedge ref_clk);
    chk("macro reset", 16'h0001, converter_reset_reg);
    #1 reset = 1'b0;
    rd(17'h1ED00, 16'h0004, "control");
    rd(17'h1ED08, 16'h0000, "divisor");
    rd(17'h1ED10, 16'h0000, "unmapped");
    chk("clock enable", 16'h0001, converter_clk_en);
    for (c = 0; c < 5; c = c + 1) begin
      bus(1'b1, 17'h1ED00, c * 4 + (c % 2) * 2);
      chk("select", c, channel_select_field_reg);
      chk("power down", c % 2, power_down_line_reg);
    end
    $display("register test end");
    t_conv(8'h00, 10'h3FF);
    t_conv(8'h09, 10'h000);
    t_conv(8'h7F, 10'h2A5);
    @(posedge ref_clk) #1 controller_reset_n = 1'b0;
    @(posedge ref_clk) #1 chk("macro reset", 16'h0001, converter_reset_reg);
    controller_reset_n = 1'b1;
    rd(17'h1ED08, 16'h0000, "divisor");
    rd(17'h1ED0C, 16'h0000, "ready flag");
    $display("reset test end");
    end_of_test;
  end
endmodule
bind acc_controller acc_asserts acc_asserts_inst (.*);
